// >>> design/digipot_defines.vh
// Purpose: Shared constants for the dual digital pot serial control logic.
// Assumes: 25 MHz system clock; 24-bit serial frames sent MSB first.
// Notes:   Definitions only; included by bare name.
`ifndef DIGIPOT_DEFINES_VH
`define DIGIPOT_DEFINES_VH

// Frame layout
`define FRAME_BITS        5'h18
`define FRAME_MSB         23
`define CMD_MSB           23
`define CMD_LSB           20
`define SLOT_MSB          19
`define SLOT_LSB          18
`define CHSEL_HI_BIT      17
`define CHSEL_LO_BIT      16
`define BUF_BIT           8
`define DATA_MSB          7
`define DATA_LSB          0
`define PAD_BITS          7'h00

// Command codes
`define CMD_NOP           4'h0
`define CMD_WR_WIPER      4'h1
`define CMD_RD_WIPER      4'h2
`define CMD_RD_PRESET     4'h4
`define CMD_WR_PRESET     4'h5
`define CMD_LOAD_WIPER    4'h6
`define CMD_SAVE_WIPER    4'h7
`define CMD_INC_WIPER     4'h8
`define CMD_DEC_WIPER     4'h9

// Reset values and scale ends
`define PRESET_RESET      9'h080
`define WIPER_RESET       8'h00
`define WIPER_MAX         8'hFF
`define WIPER_MIN         8'h00
`define CNT_RESET         5'h00
`define FRAME_RESET       24'h00_0000
`define BUSY_RESET        16'h0000

// Timing
`define CLK_PERIOD_NS     40
`define NV_ACCESS_NS      2000
// Rounded-up quotient of the two above, sized to match the 16-bit parameter
`define NV_ACCESS_CYCLES  16'h0032

`endif

// >>> design/pin_sync.v
// Purpose: Two-stage synchroniser for the four serial link input pins.
// Assumes: Pins are asynchronous to i_clk_sys.
// Notes:   Only the second stage is visible outside.
`default_nettype none

module pin_sync (
    input  wire       i_clk_sys,   // System clock
    input  wire       i_reset_n,   // Synchronous reset, active low
    input  wire [3:0] i_async,     // Raw pin levels
    output reg  [3:0] o_sync       // Synchronised levels
);

    reg [3:0] meta;

    // Idle pin levels: clock low, select high, data high, lock released
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            meta   <= 4'h7;
            o_sync <= 4'h7;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule // pin_sync

`default_nettype wire

// >>> design/preset_store.v
// Purpose: Preset storage, four 9-bit slots for each of two channels.
// Assumes: Index is {channel, slot}; one write port, one read port.
// Notes:   Flip-flops stand in for non-volatile cells; reset loads a default.
`default_nettype none
`include "digipot_defines.vh"

module preset_store (
    input  wire       i_clk_sys,   // System clock
    input  wire       i_reset_n,   // Synchronous reset, active low
    input  wire       i_wr_en,     // Write strobe
    input  wire [2:0] i_wr_idx,    // Write index {channel, slot}
    input  wire [8:0] i_wr_data,   // Buffer bit and wiper value
    input  wire [2:0] i_rd_idx,    // Read index {channel, slot}
    output wire [8:0] o_rd_data    // Read data
);

    reg [8:0] slot_mem [0:7];
    integer   k;

    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            for (k = 0; k < 8; k = k + 1) begin
                slot_mem[k] <= `PRESET_RESET;
            end
        end else if (i_wr_en) begin
            slot_mem[i_wr_idx] <= i_wr_data;
        end
    end

    assign o_rd_data = slot_mem[i_rd_idx];

endmodule // preset_store

`default_nettype wire

// >>> design/digipot_serial_ctrl.v
// Purpose: Serial control logic of a dual 256-step digital potentiometer.
// Assumes: Link pins are oversampled by i_clk_sys; link clock far slower.
// Notes:   Open-drain pins are out/oe pairs; oe high means pulling low.
//
// Notes on behaviour
// - Each channel has an 8-bit wiper register giving 256 positions.
// - Wiper register is volatile; the wiper output follows it directly.
// - Channels are independent: own wiper, presets and buffer enable.
// - Four preset slots per channel, written and read over the link.
// - Save copies a channel's wiper into the preset slot selected.
// - After reset, preset slot zero loads into each channel's wiper.
// - Each channel keeps its own output buffer enable bit.
// - Serial data passes through to the output for chaining.
// - Data input is sampled on each rising serial clock edge.
// - Select high: deselected, data output released.
// - Deselected: standby, unless a storage cycle is still running.
// - Select low: device active.
// - Data output is open drain: pulls low or releases.
// - First output bit at select fall, later bits at clock falls.
// - Output changes only on falling clock edges after the first bit.
// - Ready output is open drain, active high.
// - Ready shows completion of commands 2, 4, 5, 6 and 7.
// - Write lock low blocks all stored changes; preset retrieval still works.
// - Frame: 24 bits MSB first: command, address, seven pad, nine data.
// - Address bits 1:0 select channel; codes 00 and 01 only.
// - Increment and decrement step by one and saturate at the ends.
// - Shifting in pushes the previously held frame out of the data output.
`default_nettype none
`include "digipot_defines.vh"

module digipot_serial_ctrl #(
    parameter [15:0] NV_ACCESS_CYCLES = `NV_ACCESS_CYCLES   // Storage access time
) (
    input  wire       i_clk_sys,    // 25 MHz system clock
    input  wire       i_reset_n,    // Synchronous reset, active low
    input  wire       i_sclk,       // Serial link clock pin
    input  wire       i_cs_n,       // Chip select pin, active low
    input  wire       i_sdi,        // Serial data in pin
    input  wire       i_wp_n,       // Write lock pin, active low
    output reg        o_sdo_out,    // Serial data out drive level
    output reg        o_sdo_oe,     // Serial data out pull-low enable
    output reg        o_ready_out,  // Ready pin drive level
    output reg        o_ready_oe,   // Ready pin pull-low enable (busy)
    output reg  [7:0] o_wiper0,     // Channel 0 wiper position
    output reg  [7:0] o_wiper1,     // Channel 1 wiper position
    output reg        o_buf_en0,    // Channel 0 output buffer enable
    output reg        o_buf_en1,    // Channel 1 output buffer enable
    output reg        o_standby     // Standby state indicator
);

    localparam [1:0] ST_RECALL0 = 2'h0;
    localparam [1:0] ST_RECALL1 = 2'h1;
    localparam [1:0] ST_IDLE    = 2'h2;
    localparam [1:0] ST_BUSY    = 2'h3;

    // Saturating one-step move of a wiper value
    function [7:0] sat_step;
        input [7:0] val;
        input       up;
        begin
            if (up) begin
                sat_step = (val == `WIPER_MAX) ? val : val + 8'h01;
            end else begin
                sat_step = (val == `WIPER_MIN) ? val : val - 8'h01;
            end
        end
    endfunction

    // Preset store index from channel and slot
    function [2:0] preset_idx;
        input       ch;
        input [1:0] slot;
        begin
            preset_idx = {ch, slot};
        end
    endfunction

    wire [3:0] sync_bus;
    wire       sclk_s;
    wire       cs_s;
    wire       sdi_s;
    wire       wp_s;

    reg        sclk_q;
    reg        cs_q;
    reg        armed;
    reg  [4:0] bit_cnt;
    reg [23:0] frame;
    reg        sdo_bit;
    reg  [1:0] state;
    reg [15:0] busy_cnt;
    reg  [3:0] op_cmd;
    reg        op_ch;
    reg  [1:0] op_slot;
    reg  [8:0] op_data;
    reg  [7:0] wiper_pos [0:1];
    reg  [1:0] buf_en;

    wire [8:0] rd_data;
    reg  [2:0] rd_idx;
    reg        st_wr_en;
    reg  [8:0] st_wr_data;

    wire sclk_rise = sclk_s & ~sclk_q;
    wire sclk_fall = ~sclk_s & sclk_q;
    wire cs_fall   = ~cs_s & cs_q;
    wire cs_rise   = cs_s & ~cs_q;
    wire selected  = ~cs_s & armed;
    wire busy_done = (state == ST_BUSY) && (busy_cnt == `BUSY_RESET);

    // Frame fields
    wire [3:0] f_cmd   = frame[`CMD_MSB:`CMD_LSB];
    wire [1:0] f_slot  = frame[`SLOT_MSB:`SLOT_LSB];
    wire       f_ch_ok = ~frame[`CHSEL_HI_BIT];
    wire       f_ch    = frame[`CHSEL_LO_BIT];
    wire [8:0] f_data  = frame[`BUF_BIT:`DATA_LSB];
    wire       locked  = ~wp_s;

    assign sclk_s = sync_bus[3];
    assign cs_s   = sync_bus[2];
    assign sdi_s  = sync_bus[1];
    assign wp_s   = sync_bus[0];

    pin_sync u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_async   ({i_sclk, i_cs_n, i_sdi, i_wp_n}),
        .o_sync    (sync_bus)
    );

    preset_store u_preset_store (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_wr_en   (st_wr_en),
        .i_wr_idx  (preset_idx(op_ch, op_slot)),
        .i_wr_data (st_wr_data),
        .i_rd_idx  (rd_idx),
        .o_rd_data (rd_data)
    );

    // Read index: slot zero during recall, else the pending operation
    always @* begin
        case (state)
            ST_RECALL0: rd_idx = preset_idx(1'b0, 2'h0);
            ST_RECALL1: rd_idx = preset_idx(1'b1, 2'h0);
            default:    rd_idx = preset_idx(op_ch, op_slot);
        endcase
    end

    // Store write fires at the end of the access time
    always @* begin
        st_wr_en   = busy_done &&
                     ((op_cmd == `CMD_WR_PRESET) || (op_cmd == `CMD_SAVE_WIPER));
        st_wr_data = op_data;
        if (op_cmd == `CMD_SAVE_WIPER) begin
            st_wr_data = {buf_en[op_ch], wiper_pos[op_ch]};
        end
    end

    // Edge history and arming after the first select fall
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
            armed  <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
            cs_q   <= cs_s;
            if (cs_fall) begin
                armed <= 1'b1;
            end
        end
    end

    // Frame shifter, read reply loading and the output bit
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            frame   <= `FRAME_RESET;
            bit_cnt <= `CNT_RESET;
            sdo_bit <= 1'b1;
        end else begin
            if (cs_fall) begin
                bit_cnt <= `CNT_RESET;
                sdo_bit <= frame[`FRAME_MSB];
            end else if (sclk_rise && selected) begin
                frame <= {frame[`FRAME_MSB-1:0], sdi_s};
                if (bit_cnt != `FRAME_BITS) begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end else if (sclk_fall && selected) begin
                sdo_bit <= frame[`FRAME_MSB];
            end
            // Read reply replaces the held frame; next frame shifts it out
            if (busy_done && (op_cmd == `CMD_RD_WIPER)) begin
                frame <= {op_cmd, op_slot, 1'b0, op_ch, `PAD_BITS,
                          buf_en[op_ch], wiper_pos[op_ch]};
            end else if (busy_done && (op_cmd == `CMD_RD_PRESET)) begin
                frame <= {op_cmd, op_slot, 1'b0, op_ch, `PAD_BITS, rd_data};
            end
        end
    end

    // Command execution and storage access timing
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state        <= ST_RECALL0;
            busy_cnt     <= `BUSY_RESET;
            op_cmd       <= `CMD_NOP;
            op_ch        <= 1'b0;
            op_slot      <= 2'h0;
            op_data      <= `PRESET_RESET;
            wiper_pos[0] <= `WIPER_RESET;
            wiper_pos[1] <= `WIPER_RESET;
            buf_en       <= 2'h0;
        end else begin
            case (state)
                ST_RECALL0: begin
                    wiper_pos[0] <= rd_data[`DATA_MSB:`DATA_LSB];
                    buf_en[0]    <= rd_data[`BUF_BIT];
                    state        <= ST_RECALL1;
                end
                ST_RECALL1: begin
                    wiper_pos[1] <= rd_data[`DATA_MSB:`DATA_LSB];
                    buf_en[1]    <= rd_data[`BUF_BIT];
                    state        <= ST_IDLE;
                end
                ST_IDLE: begin
                    // Only whole frames to a valid channel act; longer ones keep
                    // their last 24 bits, as a chain needs
                    if (cs_rise && armed && (bit_cnt == `FRAME_BITS) && f_ch_ok) begin
                        op_cmd  <= f_cmd;
                        op_ch   <= f_ch;
                        op_slot <= f_slot;
                        op_data <= f_data;
                        case (f_cmd)
                            `CMD_WR_WIPER: begin
                                if (!locked) begin
                                    wiper_pos[f_ch] <= f_data[`DATA_MSB:`DATA_LSB];
                                end
                            end
                            `CMD_INC_WIPER, `CMD_DEC_WIPER: begin
                                if (!locked) begin
                                    wiper_pos[f_ch] <= sat_step(wiper_pos[f_ch],
                                        f_cmd == `CMD_INC_WIPER);
                                end
                            end
                            `CMD_RD_WIPER, `CMD_RD_PRESET, `CMD_LOAD_WIPER: begin
                                busy_cnt <= NV_ACCESS_CYCLES - 16'h0001;
                                state    <= ST_BUSY;
                            end
                            `CMD_WR_PRESET, `CMD_SAVE_WIPER: begin
                                if (!locked) begin
                                    busy_cnt <= NV_ACCESS_CYCLES - 16'h0001;
                                    state    <= ST_BUSY;
                                end
                            end
                            default: begin
                                state <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_BUSY: begin
                    if (busy_cnt == `BUSY_RESET) begin
                        state <= ST_IDLE;
                        if (op_cmd == `CMD_LOAD_WIPER) begin
                            wiper_pos[op_ch] <= rd_data[`DATA_MSB:`DATA_LSB];
                            buf_en[op_ch]    <= rd_data[`BUF_BIT];
                        end
                    end else begin
                        busy_cnt <= busy_cnt - 16'h0001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Registered pin and status outputs
    always @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_sdo_out   <= 1'b0;
            o_sdo_oe    <= 1'b0;
            o_ready_out <= 1'b0;
            o_ready_oe  <= 1'b1;
            o_wiper0    <= `WIPER_RESET;
            o_wiper1    <= `WIPER_RESET;
            o_buf_en0   <= 1'b0;
            o_buf_en1   <= 1'b0;
            o_standby   <= 1'b0;
        end else begin
            o_sdo_out   <= 1'b0;
            o_sdo_oe    <= selected & ~sdo_bit;
            o_ready_out <= 1'b0;
            o_ready_oe  <= (state != ST_IDLE);
            o_wiper0    <= wiper_pos[0];
            o_wiper1    <= wiper_pos[1];
            o_buf_en0   <= buf_en[0];
            o_buf_en1   <= buf_en[1];
            o_standby   <= cs_s & (state == ST_IDLE);
        end
    end

endmodule // digipot_serial_ctrl

`default_nettype wire

// >>> tb/digipot_checker_properties.sv
// Purpose: Port-level assertions for the dual digipot serial control block.
// Assumes: Link pins slow against i_clk_sys; sync lag of a few clocks.
// Notes:   Bound to every digipot_serial_ctrl instance below.
`default_nettype none
module digipot_checker #(
    parameter [15:0] NV_ACCESS_CYCLES = 16'h0032  // Storage access time
) (
    input wire logic       i_clk_sys,    // System clock
    input wire logic       i_reset_n,    // Synchronous reset, active low
    input wire logic       i_sclk,       // Link clock pin
    input wire logic       i_cs_n,       // Select pin
    input wire logic       i_sdi,        // Data in pin
    input wire logic       i_wp_n,       // Write lock pin
    input wire logic       o_sdo_out,    // Data out level
    input wire logic       o_sdo_oe,     // Data out pull-low enable
    input wire logic       o_ready_out,  // Ready level
    input wire logic       o_ready_oe,   // Ready pull-low enable
    input wire logic [7:0] o_wiper0,     // Channel 0 wiper
    input wire logic [7:0] o_wiper1,     // Channel 1 wiper
    input wire logic       o_buf_en0,    // Channel 0 buffer enable
    input wire logic       o_buf_en1,    // Channel 1 buffer enable
    input wire logic       o_standby     // Standby indicator
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sclk_q;
    logic        cs_q;
    logic        armed;
    logic [7:0]  since_evt;
    logic [15:0] busy_len;
    // Busy count only trusted once the host has selected; recall busy is shorter
    always @(posedge i_clk_sys) begin
        sclk_q <= i_sclk;
        cs_q <= i_cs_n;
        busy_len <= o_ready_oe ? busy_len + 16'h0001 : 16'h0000;
        if (!i_reset_n) begin
            armed <= 1'b0;
            since_evt <= 8'hFF;
        end else begin
            if (!i_cs_n) armed <= 1'b1;
            if ((sclk_q && !i_sclk) || (cs_q != i_cs_n)) since_evt <= 8'h00;
            else if (since_evt != 8'hFF) since_evt <= since_evt + 8'h01;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sdo_open_drain_a: assert property (o_sdo_out == 1'b0)
        else $error("data out drives high");
    ready_open_drain_a: assert property (o_ready_out == 1'b0)
        else $error("ready drives high");
    desel_release_a: assert property (i_cs_n [*6] |-> !o_sdo_oe)
        else $error("data out held while deselected");
    select_active_a: assert property (!i_cs_n [*6] |-> !o_standby)
        else $error("standby while selected");
    standby_entry_a: assert property ((i_cs_n && !o_ready_oe) [*6] |-> o_standby)
        else $error("no standby while idle and deselected");
    busy_no_standby_a: assert property (o_ready_oe |-> !o_standby)
        else $error("standby while a storage cycle runs");
    sdo_edge_a: assert property ($changed(o_sdo_oe) |-> since_evt <= 8'h06)
        else $error("data out moved away from clock fall or select edge");
    busy_length_a: assert property ($fell(o_ready_oe) && armed |->
        busy_len >= NV_ACCESS_CYCLES && busy_len <= NV_ACCESS_CYCLES + 16'h0001)
        else $error("busy length wrong");
    busy_cause_a: assert property ($rose(o_ready_oe) && armed |-> i_cs_n)
        else $error("busy began while selected");
    power_recall_a: assert property ($rose(i_reset_n) |-> ##6
        (o_wiper0 == 8'h80 && o_wiper1 == 8'h80 && !o_buf_en0 && !o_buf_en1))
        else $error("slot zero not recalled");
    cover property ($rose(o_ready_oe) && armed);
    cover property ($rose(o_sdo_oe));
    cover property (o_wiper0 == 8'hFF);
endmodule // digipot_checker

bind digipot_serial_ctrl digipot_checker #(.NV_ACCESS_CYCLES(NV_ACCESS_CYCLES)) u_chk (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
    .i_sdi(i_sdi), .i_wp_n(i_wp_n), .o_sdo_out(o_sdo_out), .o_sdo_oe(o_sdo_oe),
    .o_ready_out(o_ready_out), .o_ready_oe(o_ready_oe), .o_wiper0(o_wiper0),
    .o_wiper1(o_wiper1), .o_buf_en0(o_buf_en0), .o_buf_en1(o_buf_en1),
    .o_standby(o_standby));
`default_nettype wire

// >>> tb/host_model.sv
// Purpose: Host side of the serial link: select, link clock, data in.
// Assumes: Link clock 320 ns, 4 system clocks low and 4 high.
// Notes:   Samples the data out line as the link clock rises.
`default_nettype none
module host_model (
    input  wire logic i_clk_sys,  // System clock
    input  wire logic i_sdo,      // Data out line level
    output var logic  o_sclk,     // Link clock, idle low
    output var logic  o_cs_n,     // Select, idle high
    output var logic  o_sdi       // Data to the device
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // Sets select to lvl, flips data in, then waits eight system clocks
    task automatic sel(input logic lvl);
        @(posedge i_clk_sys);
        o_cs_n <= lvl;
        o_sdi <= ~o_sdi;
        wait_clk(8);
    endtask
    // Data changes while the clock is low, so it is stable at the rise
    task automatic shift(input logic [23:0] f, output logic [23:0] rx);
        for (int i = 23; i >= 0; i--) begin
            @(posedge i_clk_sys);
            o_sclk <= 1'b0;
            o_sdi <= f[i];
            wait_clk(4);
            o_sclk <= 1'b1;
            #1 rx[i] = i_sdo;
            wait_clk(3);
        end
        @(posedge i_clk_sys);
        o_sclk <= 1'b0;
        wait_clk(4);
    endtask
endmodule // host_model
`default_nettype wire

// >>> tb/digipot_serial_ctrl_test.sv
// Purpose: Self-checking bench for the dual digipot serial control block.
// Assumes: Short storage access count to keep the run brief.
// Notes:   Replies to reads come out during the following frame.
`default_nettype none
`include "digipot_defines.vh"
module digipot_serial_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [15:0] NV_CYC = 16'h000C;
    logic        i_clk_sys;
    logic        i_reset_n;
    logic        i_wp_n;
    wire         sclk;
    wire         cs_n;
    wire         sdi;
    wire         sdo_line;
    logic        sdo_out;
    logic        sdo_oe;
    logic        ready_out;
    logic        ready_oe;
    logic        buf_en0;
    logic        buf_en1;
    logic        standby;
    logic [7:0]  wiper0;
    logic [7:0]  wiper1;
    logic [23:0] rx;
    logic [23:0] rx2;
    int          num_errors;
    int          n_tests;
    int          cycles;
    assign sdo_line = sdo_oe ? 1'b0 : 1'b1;  // Pull-up on the open-drain line

    digipot_serial_ctrl #(.NV_ACCESS_CYCLES(NV_CYC)) dut (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_sdi(sdi), .i_wp_n(i_wp_n), .o_sdo_out(sdo_out), .o_sdo_oe(sdo_oe),
        .o_ready_out(ready_out), .o_ready_oe(ready_oe), .o_wiper0(wiper0),
        .o_wiper1(wiper1), .o_buf_en0(buf_en0), .o_buf_en1(buf_en1), .o_standby(standby));
    host_model host (.i_clk_sys(i_clk_sys), .i_sdo(sdo_line), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_sdi(sdi));

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    function automatic logic [23:0] fr(input logic [3:0] c, input logic [1:0] s,
        input logic [1:0] ch, input logic b, input logic [7:0] v);
        return {c, s, ch, 7'h00, b, v};
    endfunction
    task automatic send(input logic [23:0] f);
        host.sel(1'b0);
        host.shift(f, rx);
        host.sel(1'b1);
    endtask
    task automatic wait_ready;
        int k;
        k = 0;
        while (ready_oe !== 1'b0 && k < 200) begin
            @(posedge i_clk_sys);
            k++;
        end
        check(ready_oe, 24'h00_0000, "ready wait");
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic t_recall;
        check({wiper1, wiper0}, 16'h8080, "recall wipers");
        check({buf_en1, buf_en0}, 2'b00, "recall buffers");
        check(ready_oe, 1'b0, "ready after recall");
        check(standby, 1'b1, "standby when idle");
        $display("test recall done");
    endtask
    task automatic t_incdec;
        send(fr(`CMD_WR_WIPER, 2'h0, 2'h0, 1'b0, 8'hFE));
        send(fr(`CMD_INC_WIPER, 2'h0, 2'h0, 1'b0, 8'h00));
        check(wiper0, 8'hFF, "one step up");
        send(fr(`CMD_INC_WIPER, 2'h0, 2'h0, 1'b0, 8'h00));
        check(wiper0, 8'hFF, "top saturate");
        send(fr(`CMD_WR_WIPER, 2'h0, 2'h1, 1'b0, 8'h01));
        send(fr(`CMD_DEC_WIPER, 2'h0, 2'h1, 1'b0, 8'h00));
        check(wiper1, 8'h00, "one step down");
        send(fr(`CMD_DEC_WIPER, 2'h0, 2'h1, 1'b0, 8'h00));
        check({wiper1, wiper0}, 16'h00FF, "bottom saturate, ch0 apart");
        send(fr(`CMD_WR_WIPER, 2'h0, 2'h2, 1'b0, 8'h33));
        check({wiper1, wiper0}, 16'h00FF, "unused channel code");
        $display("test incdec done");
    endtask
    task automatic t_preset;
        send(fr(`CMD_WR_PRESET, 2'h2, 2'h1, 1'b1, 8'h5A));
        check(ready_oe, 1'b1, "busy after preset write");
        check(standby, 1'b0, "no standby while busy");
        wait_ready;
        send(fr(`CMD_LOAD_WIPER, 2'h2, 2'h1, 1'b0, 8'h00));
        wait_ready;
        check({buf_en1, wiper1}, 9'h15A, "load slot");
        check({buf_en0, wiper0}, 9'h0FF, "ch0 buffer apart");
        send(fr(`CMD_SAVE_WIPER, 2'h3, 2'h0, 1'b0, 8'h00));
        wait_ready;
        send(fr(`CMD_RD_PRESET, 2'h3, 2'h0, 1'b0, 8'h00));
        wait_ready;
        send(fr(`CMD_NOP, 2'h0, 2'h0, 1'b0, 8'h00));
        check(rx, fr(`CMD_RD_PRESET, 2'h3, 2'h0, 1'b0, 8'hFF), "saved slot");
        $display("test preset done");
    endtask
    task automatic t_rdwiper;
        send(fr(`CMD_RD_WIPER, 2'h0, 2'h1, 1'b0, 8'h00));
        wait_ready;
        send(fr(`CMD_NOP, 2'h0, 2'h0, 1'b0, 8'h00));
        check(rx, fr(`CMD_RD_WIPER, 2'h0, 2'h1, 1'b1, 8'h5A), "wiper reply");
        $display("test read wiper done");
    endtask
    task automatic t_lock;
        @(posedge i_clk_sys);
        i_wp_n <= 1'b0;
        send(fr(`CMD_WR_WIPER, 2'h0, 2'h0, 1'b0, 8'h44));
        check(wiper0, 8'hFF, "locked write");
        send(fr(`CMD_WR_PRESET, 2'h1, 2'h0, 1'b1, 8'h44));
        check(ready_oe, 1'b0, "locked preset no busy");
        send(fr(`CMD_RD_PRESET, 2'h1, 2'h0, 1'b0, 8'h00));
        wait_ready;
        send(fr(`CMD_NOP, 2'h0, 2'h0, 1'b0, 8'h00));
        check(rx, fr(`CMD_RD_PRESET, 2'h1, 2'h0, 1'b0, 8'h80), "locked read");
        @(posedge i_clk_sys);
        i_wp_n <= 1'b1;
        $display("test lock done");
    endtask
    task automatic t_chain;
        host.sel(1'b0);
        host.shift(fr(`CMD_WR_WIPER, 2'h0, 2'h0, 1'b0, 8'h11), rx);
        host.shift(fr(`CMD_WR_WIPER, 2'h0, 2'h0, 1'b0, 8'h22), rx2);
        host.sel(1'b1);
        check(rx2, fr(`CMD_WR_WIPER, 2'h0, 2'h0, 1'b0, 8'h11), "passed on");
        check(wiper0, 8'h22, "last frame kept");
        $display("test chain done");
    endtask

    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    // Ceiling well above the roughly 4300 cycles the tests need
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            final_report;
        end
    end
    initial begin
        i_reset_n = 1'b0;
        i_wp_n = 1'b1;
        num_errors = 0;
        n_tests = 0;
        cycles = 0;
        repeat (10) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        t_recall;
        t_incdec;
        t_preset;
        t_rdwiper;
        t_lock;
        t_chain;
        final_report;
    end
endmodule // digipot_serial_ctrl_test
`default_nettype wire
